// ### logic/sbmx_defs.svh
`ifndef SBMX_DEFS_SVH
`define SBMX_DEFS_SVH
`define SBMX_FILE_DEPTH 32
`define SBMX_STATUS_ADDR 5'h03
`define SBMX_Z_BIT 2
`define SBMX_PAGE_HI 6
`define SBMX_PAGE_LO 5
`define SBMX_ACC_RESET 8'h00
`define SBMX_PC_RESET 11'h7ff
`define SBMX_STATUS_RESET 8'h18
`endif

// ### logic/sbmx_exec.sv
// How it works
// [RULE1] decrement register, d picks destination
// [RULE2] zero skip result flushes next instruction
// [RULE3] increment register, d picks destination, skip zero
// [RULE4] jump loads k and status page bits
// [RULE5] or literal into accumulator, update zero
// [RULE6] or register, d picks destination, zero
// [RULE7] move accumulator to register, flags unchanged
// [RULE8] skips and jump leave status alone
`timescale 1ns/10ps
`include "sbmx_defs.svh"
module sbmx_exec (
  input wire logic CLOCK,
  input wire logic RESET_N,
  input wire logic ISSUE,
  input wire sbmx_pkg::sbmx_op_t OPCODE,
  input wire logic [4:0] FILE_ADDR,
  input wire logic DEST,
  input wire logic [8:0] LITERAL,
  output logic [7:0] ACCUMULATOR,
  output logic [7:0] STATUS,
  output logic [10:0] PC,
  output logic PC_LOAD,
  output logic BUSY,
  output logic DONE
);
  sbmx_pkg::sbmx_state_t state, next_state;
  sbmx_pkg::sbmx_op_t op;
  logic [4:0] addr;
  logic dest;
  logic [7:0] lit;
  logic [7:0] rdata;
  logic [7:0] result;
  logic we;
  logic [7:0] next_acc, next_status;
  logic [10:0] next_pc;
  logic next_pc_load, next_busy, next_done;
  logic [7:0] status_rd;
  logic [8:0] jump_k;
  sbmx_pkg::sbmx_op_t next_op;
  logic [4:0] next_addr;
  logic next_dest;
  logic [7:0] next_lit;
  logic [8:0] next_jump_k;
  logic take;
  // an issue is taken only while no flush is pending
  assign take = ISSUE && !BUSY;
  always_comb begin
    next_op = sbmx_pkg::SBMX_NOP;
    next_addr = addr;
    next_dest = dest;
    next_lit = lit;
    next_jump_k = jump_k;
    if (take) begin
      next_op = OPCODE;
      next_addr = FILE_ADDR;
      next_dest = DEST;
      next_lit = LITERAL[7:0];
      next_jump_k = LITERAL;
    end
  end
  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      op <= sbmx_pkg::SBMX_NOP;
      addr <= 5'h00;
      dest <= 1'b0;
      lit <= 8'h00;
      jump_k <= 9'h000;
    end else begin
      op <= next_op;
      addr <= next_addr;
      dest <= next_dest;
      lit <= next_lit;
      jump_k <= next_jump_k;
    end
  end
  sbmx_file_mem u_mem (
    .clock(CLOCK),
    .reset_n(RESET_N),
    .raddr(FILE_ADDR),
    .rdata(rdata),
    .we(we),
    .waddr(addr),
    .wdata(result)
  );
  assign status_rd = STATUS;
  always_comb begin
    next_acc = ACCUMULATOR;
    next_status = STATUS;
    next_pc = PC;
    next_pc_load = 1'b0;
    next_busy = 1'b0;
    next_done = 1'b0;
    next_state = sbmx_pkg::SBMX_RUN;
    result = 8'h00;
    we = 1'b0;
    unique case (state)
      sbmx_pkg::SBMX_RUN: begin
        next_done = op != sbmx_pkg::SBMX_NOP;
        unique case (op)
          sbmx_pkg::SBMX_DEC_SKIP, sbmx_pkg::SBMX_INC_SKIP: begin // [RULE8]
            result = (op == sbmx_pkg::SBMX_DEC_SKIP) ? rdata - 8'h01 : rdata + 8'h01; // [RULE1] [RULE3]
            we = dest;
            if (!dest) begin
              next_acc = result;
            end
            if (result == 8'h00) begin
              next_state = sbmx_pkg::SBMX_FLUSH; // [RULE2]
              next_busy = 1'b1;
              next_done = 1'b0;
            end
          end
          sbmx_pkg::SBMX_JUMP: begin // [RULE8]
            next_pc = {status_rd[`SBMX_PAGE_HI:`SBMX_PAGE_LO], jump_k}; // [RULE4]
            next_pc_load = 1'b1;
            next_state = sbmx_pkg::SBMX_FLUSH;
            next_busy = 1'b1;
            next_done = 1'b0;
          end
          sbmx_pkg::SBMX_OR_LIT: begin
            result = ACCUMULATOR | lit; // [RULE5]
            next_acc = result;
            next_status[`SBMX_Z_BIT] = result == 8'h00;
          end
          sbmx_pkg::SBMX_OR_REG: begin
            result = ACCUMULATOR | rdata; // [RULE6]
            we = dest;
            if (!dest) begin
              next_acc = result;
            end
            next_status[`SBMX_Z_BIT] = result == 8'h00;
          end
          sbmx_pkg::SBMX_MOVE_REG: begin
            result = ACCUMULATOR; // [RULE7]
            we = 1'b1;
          end
          sbmx_pkg::SBMX_NOP: begin
          end
          default: begin
          end
        endcase
      end
      sbmx_pkg::SBMX_FLUSH: begin
        next_done = 1'b1; // [RULE2]
      end
      default: begin
      end
    endcase
  end
  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      state <= sbmx_pkg::SBMX_RUN;
      ACCUMULATOR <= `SBMX_ACC_RESET;
      STATUS <= `SBMX_STATUS_RESET;
      PC <= `SBMX_PC_RESET;
      PC_LOAD <= 1'b0;
      BUSY <= 1'b0;
      DONE <= 1'b0;
    end else begin
      state <= next_state;
      ACCUMULATOR <= next_acc;
      STATUS <= next_status;
      PC <= next_pc;
      PC_LOAD <= next_pc_load;
      BUSY <= next_busy;
      DONE <= next_done;
    end
  end
  sequence s_skip_zero;
    (op == sbmx_pkg::SBMX_DEC_SKIP || op == sbmx_pkg::SBMX_INC_SKIP) && state == sbmx_pkg::SBMX_RUN
      && result == 8'h00;
  endsequence
  // flush cycle: busy without done, then done with busy dropped
  sequence s_flush_tail;
    BUSY && !DONE ##1 DONE && !BUSY;
  endsequence
  a_skip_flush: assert property (@(posedge CLOCK) disable iff (!RESET_N) // [RULE2]
    s_skip_zero |=> s_flush_tail)
    else $error("zero skip did not flush one cycle");
  a_skip_to_file: assert property (@(posedge CLOCK) disable iff (!RESET_N) // [RULE1] [RULE3]
    op inside {sbmx_pkg::SBMX_DEC_SKIP, sbmx_pkg::SBMX_INC_SKIP}
      && state == sbmx_pkg::SBMX_RUN && dest |-> we ##1 $stable(ACCUMULATOR))
    else $error("skip to file register missed write or touched accumulator");
  a_dec_value: assert property (@(posedge CLOCK) disable iff (!RESET_N) // [RULE1]
    op == sbmx_pkg::SBMX_DEC_SKIP && state == sbmx_pkg::SBMX_RUN && !dest
      |=> ACCUMULATOR == $past(rdata) - 8'h01)
    else $error("decrement result wrong");
  a_inc_value: assert property (@(posedge CLOCK) disable iff (!RESET_N) // [RULE3]
    op == sbmx_pkg::SBMX_INC_SKIP && state == sbmx_pkg::SBMX_RUN && !dest
      |=> ACCUMULATOR == $past(rdata) + 8'h01)
    else $error("increment result wrong");
  a_jump_pc: assert property (@(posedge CLOCK) disable iff (!RESET_N) // [RULE4]
    op == sbmx_pkg::SBMX_JUMP && state == sbmx_pkg::SBMX_RUN
      |=> PC_LOAD && PC == {$past(STATUS[6:5]), $past(jump_k)} ##1 DONE)
    else $error("jump target or timing wrong");
  a_jump_two: assert property (@(posedge CLOCK) disable iff (!RESET_N) // [RULE4]
    op == sbmx_pkg::SBMX_JUMP && state == sbmx_pkg::SBMX_RUN |=> s_flush_tail)
    else $error("jump did not take two cycles");
  a_pc_only_jump: assert property (@(posedge CLOCK) disable iff (!RESET_N) // [RULE4]
    $changed(PC) |-> PC_LOAD)
    else $error("program counter moved without a jump");
  a_or_lit: assert property (@(posedge CLOCK) disable iff (!RESET_N) // [RULE5]
    op == sbmx_pkg::SBMX_OR_LIT && state == sbmx_pkg::SBMX_RUN
      |=> ACCUMULATOR == ($past(ACCUMULATOR) | $past(lit))
      && STATUS[2] == (ACCUMULATOR == 8'h00))
    else $error("or literal wrong");
  a_or_reg: assert property (@(posedge CLOCK) disable iff (!RESET_N) // [RULE6]
    op == sbmx_pkg::SBMX_OR_REG && state == sbmx_pkg::SBMX_RUN
      |=> STATUS[2] == (($past(ACCUMULATOR) | $past(rdata)) == 8'h00))
    else $error("or register zero flag wrong");
  a_or_reg_acc: assert property (@(posedge CLOCK) disable iff (!RESET_N) // [RULE6]
    op == sbmx_pkg::SBMX_OR_REG && state == sbmx_pkg::SBMX_RUN && !dest
      |=> ACCUMULATOR == ($past(ACCUMULATOR) | $past(rdata)))
    else $error("or register accumulator result wrong");
  a_or_reg_file: assert property (@(posedge CLOCK) disable iff (!RESET_N) // [RULE6]
    op == sbmx_pkg::SBMX_OR_REG && state == sbmx_pkg::SBMX_RUN && dest
      |-> we ##1 $stable(ACCUMULATOR))
    else $error("or register to file missed write or touched accumulator");
  a_move_keep: assert property (@(posedge CLOCK) disable iff (!RESET_N) // [RULE7]
    op == sbmx_pkg::SBMX_MOVE_REG && state == sbmx_pkg::SBMX_RUN
      |-> we && result == ACCUMULATOR ##1 $stable(STATUS))
    else $error("move changed flags or missed write");
  a_skip_status: assert property (@(posedge CLOCK) disable iff (!RESET_N) // [RULE8]
    op inside {sbmx_pkg::SBMX_DEC_SKIP, sbmx_pkg::SBMX_INC_SKIP, sbmx_pkg::SBMX_JUMP}
      |=> $stable(STATUS))
    else $error("skip or jump changed status");
endmodule : sbmx_exec

// ### logic/sbmx_file_mem.sv
`timescale 1ns/10ps
`include "sbmx_defs.svh"
module sbmx_file_mem (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic [4:0] raddr,
  output logic [7:0] rdata,
  input wire logic we,
  input wire logic [4:0] waddr,
  input wire logic [7:0] wdata
);
  logic [7:0] mem [`SBMX_FILE_DEPTH];
  logic [7:0] next_rdata;
  always_comb begin
    next_rdata = mem[raddr];
    if (we && waddr == raddr) begin
      next_rdata = wdata;
    end
  end
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      rdata <= 8'h00;
    end else begin
      rdata <= next_rdata;
    end
  end
  always_ff @(posedge clock) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end
endmodule : sbmx_file_mem

// ### logic/sbmx_pkg.sv
package sbmx_pkg;
  typedef enum logic [2:0] {
    SBMX_NOP = 3'b000,
    SBMX_DEC_SKIP = 3'b001,
    SBMX_INC_SKIP = 3'b010,
    SBMX_JUMP = 3'b011,
    SBMX_OR_LIT = 3'b100,
    SBMX_OR_REG = 3'b101,
    SBMX_MOVE_REG = 3'b110
  } sbmx_op_t;
  typedef enum logic [1:0] {
    SBMX_RUN = 2'b00,
    SBMX_FLUSH = 2'b01
  } sbmx_state_t;
endpackage : sbmx_pkg

// ### test/skip_branch_or_move_exec_tb_top.sv
`timescale 1ns/10ps
module skip_branch_or_move_exec_tb_top;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic issue = 1'b0;
  sbmx_pkg::sbmx_op_t opc = sbmx_pkg::SBMX_NOP;
  logic [4:0] fa = 5'h00;
  logic dst = 1'b0;
  logic [8:0] lit = 9'h000;
  logic [7:0] acc;
  logic [7:0] st;
  logic [10:0] pc;
  logic pcl;
  logic busy;
  logic done;
  logic seen;
  logic pl;
  int miscompares = 0;
  int n_checks = 0;
  int cyc = 0;
  int cnt;
  sbmx_exec i_sbmx_exec (.CLOCK(clk), .RESET_N(rst_n), .ISSUE(issue), .OPCODE(opc),
    .FILE_ADDR(fa), .DEST(dst), .LITERAL(lit), .ACCUMULATOR(acc), .STATUS(st), .PC(pc),
    .PC_LOAD(pcl), .BUSY(busy), .DONE(done));
  initial begin
    forever #20 clk = ~clk;
  end
  task automatic wrap_up;
    if (miscompares == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : wrap_up
  task automatic chk(input logic [10:0] got, input logic [10:0] exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // issue one op, count cycles to done, then compare accumulator and status
  task automatic run(input sbmx_pkg::sbmx_op_t o, input logic [4:0] a, input logic d,
      input logic [8:0] k, input int n, input logic [7:0] ea, input logic [7:0] es);
    @(negedge clk);
    opc = o;
    fa = a;
    dst = d;
    lit = k;
    issue = 1'b1;
    seen = 1'b0;
    pl = 1'b0;
    @(negedge clk);
    issue = 1'b0;
    cnt = 1;
    while (done !== 1'b1 && cnt < 10) begin
      seen = seen | (busy === 1'b1);
      pl = pl | (pcl === 1'b1);
      @(negedge clk);
      cnt++;
    end
    chk(11'(cnt), 11'(n));
    chk(11'(seen), 11'(n == 3));
    chk(11'(acc), 11'(ea));
    chk(11'(st), 11'(es));
  endtask : run
  task automatic t_or_lit;
    run(sbmx_pkg::SBMX_OR_LIT, 5'h00, 1'b0, 9'h000, 2, 8'h00, 8'h1c);
    run(sbmx_pkg::SBMX_OR_LIT, 5'h00, 1'b0, 9'h101, 2, 8'h01, 8'h18);
  endtask : t_or_lit
  task automatic t_skips;
    run(sbmx_pkg::SBMX_MOVE_REG, 5'h00, 1'b0, 9'h000, 2, 8'h01, 8'h18);
    run(sbmx_pkg::SBMX_DEC_SKIP, 5'h00, 1'b1, 9'h000, 3, 8'h01, 8'h18);
    run(sbmx_pkg::SBMX_INC_SKIP, 5'h00, 1'b0, 9'h000, 2, 8'h01, 8'h18);
    run(sbmx_pkg::SBMX_DEC_SKIP, 5'h00, 1'b1, 9'h000, 2, 8'h01, 8'h18);
    run(sbmx_pkg::SBMX_INC_SKIP, 5'h00, 1'b0, 9'h000, 3, 8'h00, 8'h18);
  endtask : t_skips
  task automatic t_or_reg;
    run(sbmx_pkg::SBMX_MOVE_REG, 5'h01, 1'b1, 9'h000, 2, 8'h00, 8'h18);
    run(sbmx_pkg::SBMX_OR_REG, 5'h01, 1'b1, 9'h000, 2, 8'h00, 8'h1c);
    run(sbmx_pkg::SBMX_MOVE_REG, 5'h1f, 1'b0, 9'h000, 2, 8'h00, 8'h1c);
    run(sbmx_pkg::SBMX_OR_REG, 5'h00, 1'b0, 9'h000, 2, 8'hff, 8'h18);
    run(sbmx_pkg::SBMX_OR_REG, 5'h1f, 1'b1, 9'h000, 2, 8'hff, 8'h18);
    run(sbmx_pkg::SBMX_INC_SKIP, 5'h1f, 1'b0, 9'h000, 3, 8'h00, 8'h18);
  endtask : t_or_reg
  task automatic t_jump;
    run(sbmx_pkg::SBMX_JUMP, 5'h00, 1'b0, 9'h1a5, 3, 8'h00, 8'h18);
    chk(pc, 11'h1a5);
    chk(11'(pl), 11'h001);
  endtask : t_jump
  always @(posedge clk) begin
    cyc++;
    if (cyc == 1000) begin
      miscompares++;
      wrap_up();
    end
  end
  initial begin
    repeat (10) @(negedge clk);
    rst_n = 1'b1;
    chk(11'(acc), 11'h000);
    chk(11'(st), 11'h018);
    chk(pc, 11'h7ff);
    t_or_lit();
    t_skips();
    t_or_reg();
    t_jump();
    wrap_up();
  end
endmodule : skip_branch_or_move_exec_tb_top
